// [pkg/eta_pkg.sv]
package eta_pkg;
    // clock and recovery timing
    localparam int CLK_MHZ = 200;
    localparam int REC_NS = 1000;
    localparam int REC_CYC = (REC_NS * CLK_MHZ + 999) / 1000;
    // data widths
    localparam int CNT_W = 32;
    localparam int TIME_W = 48;
    localparam int RES_W = 64;
    localparam int REC_W = CNT_W + TIME_W;
    localparam int MEM_AW = 23;
    // fixed point fractions of the results
    localparam int FREQ_FRAC = 32;
    localparam int PER_FRAC = 16;
    localparam int REF_FRAC = 16;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ARM_N = 8'h04;
    localparam logic [7:0] OFS_ARM_T = 8'h08;
    localparam logic [7:0] OFS_REF = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_LEVEL = 8'h14;
    localparam logic [7:0] OFS_EVENTS = 8'h18;
    localparam logic [7:0] OFS_CMD = 8'h1c;
    localparam logic [7:0] OFS_TAG_CNT = 8'h20;
    localparam logic [7:0] OFS_TAG_TLO = 8'h24;
    localparam logic [7:0] OFS_TAG_THI = 8'h28;
    localparam logic [7:0] OFS_RES_LO = 8'h2c;
    localparam logic [7:0] OFS_RES_HI = 8'h30;
    // control field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_FALL = 1;
    localparam int CTRL_ARM = 2;
    localparam int CTRL_FN = 4;
    // status bit positions
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL = 1;
    localparam int ST_OVF = 2;
    localparam int ST_RVLD = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_REC = 5;
    // command bit positions
    localparam int CMD_POP = 0;
    localparam int CMD_REBASE = 1;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] ARM_N_RST = 32'h0000_0001;
    localparam logic [31:0] ARM_T_RST = 32'h0000_00c8;
    localparam logic [31:0] REF_RST = 32'h0000_0000;
    // arming modes and result functions
    localparam logic [1:0] ARM_EVERY_N = 2'h0;
    localparam logic [1:0] ARM_EVERY_T = 2'h1;
    localparam logic [1:0] FN_FREQ = 2'h0;
    localparam logic [1:0] FN_PERIOD = 2'h1;
    localparam logic [1:0] FN_CTI = 2'h2;
    localparam logic [1:0] FN_TIE = 2'h3;
endpackage

// [pkg/eta_if.sv]
`timescale 1ns/100ps
`default_nettype none
// record memory port between core and store
interface eta_mem_if #(parameter int AW = 23, parameter int W = 80);
    logic wr_en;
    logic [W-1:0] wr_data;
    logic rd_en;
    logic [W-1:0] rd_data;
    logic [AW:0] count;
    logic full;
    logic empty;
    modport core (output wr_en, wr_data, rd_en,
                  input rd_data, count, full, empty);
    modport mem (input wr_en, wr_data, rd_en,
                 output rd_data, count, full, empty);
endinterface

// divider request and answer
interface eta_div_if #(parameter int NW = 64, parameter int DW = 48);
    logic start;
    logic [NW-1:0] num;
    logic [DW-1:0] den;
    logic done;
    logic [NW-1:0] quot;
    modport core (output start, num, den, input done, quot);
    modport div (input start, num, den, output done, quot);
endinterface
`default_nettype wire

// [rtl/eta_tag_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module eta_tag_mem #(
    parameter int AW = 23,
    parameter int W = 80
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // record port
    eta_mem_if.mem m
);
    localparam logic [AW:0] CAP = {1'b1, {AW{1'b0}}};
    logic [W-1:0] ram [2**AW];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;
    logic [W-1:0] rd_q;
    logic do_wr, do_rd;

    // pointer arithmetic, reads may run during writes
    always_comb begin
        do_wr = m.wr_en & ~m.full;
        do_rd = m.rd_en & ~m.empty;
        wp_d = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d = do_rd ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else if (ce) begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    // storage array with registered read
    always_ff @(posedge clk) begin
        if (ce && do_wr) begin
            ram[wp_q[AW-1:0]] <= m.wr_data;
        end
        if (ce && do_rd) begin
            rd_q <= ram[rp_q[AW-1:0]];
        end
    end

    assign m.rd_data = rd_q;
    assign m.count = wp_q - rp_q;
    assign m.full = (m.count == CAP);
    assign m.empty = (wp_q == rp_q);
endmodule
`default_nettype wire

// [rtl/eta_divider.sv]
`timescale 1ns/100ps
`default_nettype none
module eta_divider #(
    parameter int NW = 64,
    parameter int DW = 48
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // request and answer
    eta_div_if.div d
);
    logic busy_q, busy_d, done_q, done_d;
    logic [6:0] cnt_q, cnt_d;
    logic [DW:0] rem_q, rem_d, sh;
    logic [NW-1:0] quo_q, quo_d;
    logic [DW-1:0] den_q, den_d;

    // restoring division, one quotient bit per cycle
    always_comb begin
        busy_d = busy_q;
        cnt_d = cnt_q;
        rem_d = rem_q;
        quo_d = quo_q;
        den_d = den_q;
        done_d = 1'b0;
        sh = {rem_q[DW-1:0], quo_q[NW-1]};
        if (d.start) begin
            busy_d = 1'b1;
            cnt_d = 7'(NW);
            rem_d = '0;
            quo_d = d.num;
            den_d = d.den;
        end else if (busy_q) begin
            if (den_q == '0) begin
                quo_d = '1; // divide by zero saturates
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                if (sh >= {1'b0, den_q}) begin
                    rem_d = sh - {1'b0, den_q};
                    quo_d = {quo_q[NW-2:0], 1'b1};
                end else begin
                    rem_d = sh;
                    quo_d = {quo_q[NW-2:0], 1'b0};
                end
                cnt_d = cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
            rem_q <= '0;
            quo_q <= '0;
            den_q <= '0;
        end else if (ce) begin
            busy_q <= busy_d;
            done_q <= done_d;
            cnt_q <= cnt_d;
            rem_q <= rem_d;
            quo_q <= quo_d;
            den_q <= den_d;
        end
    end

    assign d.done = done_q;
    assign d.quot = quo_q;
endmodule
`default_nettype wire

// [rtl/eta_event_timetag_analyzer.sv]
// What this block does
// - the digitised input is high above threshold and its chosen edge is an event.
// - the event counter counts every event, also during tag recovery.
// - arming tags either every Nth event or the first event after T cycles.
// - each tagged event stores its event count and time as one record.
// - after a tag no new tag is taken for one microsecond of recovery.
// - one channel and one tag path, each record holds one time and one count.
// - the closing tag of one result is the opening tag of the next.
// - average frequency is count change divided by time change.
// - average period is time change divided by count change.
// - continuous interval is the plain time change.
// - interval error is tag time minus the time expected from a given period.
// - record memory holds up to eight million records, readable while filled.
// - records stream out continuously while the host keeps draining them.
`timescale 1ns/100ps
`default_nettype none
module eta_event_timetag_analyzer #(
    parameter int MEM_AW = eta_pkg::MEM_AW
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // comparator output of the input channel
    input wire logic sig_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int CW = eta_pkg::CNT_W;
    localparam int TW = eta_pkg::TIME_W;
    localparam int RW = eta_pkg::RES_W;
    localparam logic [7:0] REC = 8'(eta_pkg::REC_CYC);

    typedef enum logic [1:0] {ETA_IDLE, ETA_FETCH, ETA_CALC, ETA_DIV}
        eta_state_t;

    eta_mem_if #(.AW(MEM_AW), .W(eta_pkg::REC_W)) mif ();
    eta_div_if #(.NW(RW), .DW(TW)) dif ();

    // record store
    eta_tag_mem #(.AW(MEM_AW), .W(eta_pkg::REC_W)) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .m(mif)
    );

    // serial divider for the averaged results
    eta_divider #(.NW(RW), .DW(TW)) u_div (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(dif)
    );

    // configuration and apb state
    logic [31:0] ctrl_q, ctrl_d, arm_n_q, arm_n_d, arm_t_q, arm_t_d;
    logic [31:0] ref_q, ref_d, prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic ovf_q, ovf_d;
    // acquisition state
    logic [2:0] sync_q, sync_d;
    logic [TW-1:0] tb_q, tb_d;
    logic [CW-1:0] evt_q, evt_d, since_q, since_d;
    logic [31:0] tmr_q, tmr_d;
    logic [7:0] rec_q, rec_d;
    logic tagged_q, tagged_d;
    // readout state
    eta_state_t st_q, st_d;
    logic [CW-1:0] cur_e_q, cur_e_d, prv_e_q, prv_e_d, bas_e_q, bas_e_d;
    logic [TW-1:0] cur_t_q, cur_t_d, prv_t_q, prv_t_d, bas_t_q, bas_t_d;
    logic [RW-1:0] res_q, res_d;
    logic have_q, have_d, rvld_q, rvld_d;
    // combinational helpers
    logic en, hit, armed, take, acc, fin, wr_ok, pop, rebase;
    logic [1:0] fn;
    logic [CW-1:0] n_eff, de;
    logic [TW-1:0] dt;
    logic [RW-1:0] tie_exp, tie_obs;
    logic [31:0] rdmux, status;
    logic mapped;

    // edge detection on the synchronised comparator level
    always_comb begin
        en = ctrl_q[eta_pkg::CTRL_EN];
        fn = ctrl_q[eta_pkg::CTRL_FN +: 2];
        sync_d = {sync_q[1:0], sig_in};
        if (ctrl_q[eta_pkg::CTRL_FALL]) begin
            hit = en & ~sync_q[1] & sync_q[2];
        end else begin
            hit = en & sync_q[1] & ~sync_q[2];
        end
    end

    // arming, recovery and counting
    always_comb begin
        n_eff = (arm_n_q == '0) ? 32'h0000_0001 : arm_n_q;
        if (ctrl_q[eta_pkg::CTRL_ARM +: 2] == eta_pkg::ARM_EVERY_T) begin
            armed = (tmr_q >= arm_t_q);
        end else begin
            armed = (since_q + 1'b1 >= n_eff);
        end
        take = hit & (rec_q == '0) & (~tagged_q | armed);
        tb_d = tb_q + 1'b1;
        evt_d = en ? evt_q + CW'(hit) : '0;
        since_d = since_q;
        tmr_d = (tmr_q == '1) ? tmr_q : tmr_q + 1'b1;
        rec_d = (rec_q == '0) ? rec_q : rec_q - 8'h01;
        tagged_d = tagged_q;
        if (take) begin
            since_d = '0;
            tmr_d = 32'h0000_0001; // the tag cycle counts as elapsed
            rec_d = REC - 8'h01; // next tag allowed REC cycles on
            tagged_d = 1'b1;
        end else if (hit) begin
            since_d = (since_q == '1) ? since_q : since_q + 1'b1;
        end
        if (!en) begin
            since_d = '0;
            rec_d = '0;
            tagged_d = 1'b0;
        end
        mif.wr_en = take;
        mif.wr_data = {evt_q + 1'b1, tb_q};
    end

    // result arithmetic between consecutive tags, interval error from the base tag
    always_comb begin
        de = cur_e_q - prv_e_q;
        dt = cur_t_q - prv_t_q;
        tie_obs = RW'(cur_t_q - bas_t_q) << eta_pkg::REF_FRAC;
        tie_exp = RW'(cur_e_q - bas_e_q) * RW'(ref_q);
    end

    // readout sequencing: fetch, compute, chain
    always_comb begin
        st_d = st_q;
        cur_e_d = cur_e_q;
        cur_t_d = cur_t_q;
        prv_e_d = prv_e_q;
        prv_t_d = prv_t_q;
        bas_e_d = bas_e_q;
        bas_t_d = bas_t_q;
        res_d = res_q;
        have_d = have_q;
        rvld_d = rvld_q;
        mif.rd_en = 1'b0;
        dif.start = 1'b0;
        dif.num = '0;
        dif.den = '0;
        unique case (st_q)
            ETA_IDLE: begin
                if (pop && !mif.empty) begin
                    mif.rd_en = 1'b1;
                    rvld_d = 1'b0;
                    st_d = ETA_FETCH;
                end else if (rebase) begin
                    have_d = 1'b0;
                    rvld_d = 1'b0;
                end
            end
            ETA_FETCH: begin
                {cur_e_d, cur_t_d} = mif.rd_data;
                st_d = ETA_CALC;
            end
            ETA_CALC: begin
                prv_e_d = cur_e_q;
                prv_t_d = cur_t_q;
                have_d = 1'b1;
                st_d = ETA_IDLE;
                if (!have_q) begin
                    bas_e_d = cur_e_q;
                    bas_t_d = cur_t_q;
                end else begin
                    unique case (fn)
                        eta_pkg::FN_FREQ: begin
                            dif.start = 1'b1;
                            dif.num = RW'(de) << eta_pkg::FREQ_FRAC;
                            dif.den = dt;
                            st_d = ETA_DIV;
                        end
                        eta_pkg::FN_PERIOD: begin
                            dif.start = 1'b1;
                            dif.num = RW'(dt) << eta_pkg::PER_FRAC;
                            dif.den = TW'(de);
                            st_d = ETA_DIV;
                        end
                        eta_pkg::FN_CTI: begin
                            res_d = RW'(dt);
                            rvld_d = 1'b1;
                        end
                        eta_pkg::FN_TIE: begin
                            res_d = tie_obs - tie_exp;
                            rvld_d = 1'b1;
                        end
                    endcase
                end
            end
            ETA_DIV: begin
                if (dif.done) begin
                    res_d = dif.quot;
                    rvld_d = 1'b1;
                    st_d = ETA_IDLE;
                end
            end
        endcase
    end

    // apb decode, one wait state, write at completion edge
    always_comb begin
        acc = psel & penable & ~pready_q;
        fin = psel & penable & pready_q;
        wr_ok = fin & pwrite & ~pslverr_q;
        pop = wr_ok & (paddr == eta_pkg::OFS_CMD) & pwdata[eta_pkg::CMD_POP];
        rebase = wr_ok & (paddr == eta_pkg::OFS_CMD)
            & pwdata[eta_pkg::CMD_REBASE];
        status = '0;
        status[eta_pkg::ST_EMPTY] = mif.empty;
        status[eta_pkg::ST_FULL] = mif.full;
        status[eta_pkg::ST_OVF] = ovf_q;
        status[eta_pkg::ST_RVLD] = rvld_q;
        status[eta_pkg::ST_BUSY] = (st_q != ETA_IDLE);
        status[eta_pkg::ST_REC] = (rec_q != '0);
        mapped = 1'b1;
        unique case (paddr)
            eta_pkg::OFS_CTRL: rdmux = ctrl_q;
            eta_pkg::OFS_ARM_N: rdmux = arm_n_q;
            eta_pkg::OFS_ARM_T: rdmux = arm_t_q;
            eta_pkg::OFS_REF: rdmux = ref_q;
            eta_pkg::OFS_STATUS: rdmux = status;
            eta_pkg::OFS_LEVEL: rdmux = 32'(mif.count);
            eta_pkg::OFS_EVENTS: rdmux = evt_q;
            eta_pkg::OFS_CMD: rdmux = '0;
            eta_pkg::OFS_TAG_CNT: rdmux = cur_e_q;
            eta_pkg::OFS_TAG_TLO: rdmux = cur_t_q[31:0];
            eta_pkg::OFS_TAG_THI: rdmux = 32'(cur_t_q[TW-1:32]);
            eta_pkg::OFS_RES_LO: rdmux = res_q[31:0];
            eta_pkg::OFS_RES_HI: rdmux = res_q[63:32];
            default: begin
                rdmux = '0;
                mapped = 1'b0;
            end
        endcase
        pready_d = acc;
        prdata_d = acc ? rdmux : prdata_q;
        pslverr_d = acc ? ~mapped : 1'b0;
        ctrl_d = ctrl_q;
        arm_n_d = arm_n_q;
        arm_t_d = arm_t_q;
        ref_d = ref_q;
        if (wr_ok && paddr == eta_pkg::OFS_CTRL) ctrl_d = pwdata;
        if (wr_ok && paddr == eta_pkg::OFS_ARM_N) arm_n_d = pwdata;
        if (wr_ok && paddr == eta_pkg::OFS_ARM_T) arm_t_d = pwdata;
        if (wr_ok && paddr == eta_pkg::OFS_REF) ref_d = pwdata;
        // overflow sticky, a new loss wins over the clear
        ovf_d = ovf_q;
        if (wr_ok && paddr == eta_pkg::OFS_STATUS
            && pwdata[eta_pkg::ST_OVF]) begin
            ovf_d = 1'b0;
        end
        if (take && mif.full) ovf_d = 1'b1;
    end

    // all state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= eta_pkg::CTRL_RST;
            arm_n_q <= eta_pkg::ARM_N_RST;
            arm_t_q <= eta_pkg::ARM_T_RST;
            ref_q <= eta_pkg::REF_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ovf_q <= 1'b0;
            sync_q <= '0;
            tb_q <= '0;
            evt_q <= '0;
            since_q <= '0;
            tmr_q <= '0;
            rec_q <= '0;
            tagged_q <= 1'b0;
            st_q <= ETA_IDLE;
            cur_e_q <= '0;
            cur_t_q <= '0;
            prv_e_q <= '0;
            prv_t_q <= '0;
            bas_e_q <= '0;
            bas_t_q <= '0;
            res_q <= '0;
            have_q <= 1'b0;
            rvld_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            arm_n_q <= arm_n_d;
            arm_t_q <= arm_t_d;
            ref_q <= ref_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            ovf_q <= ovf_d;
            sync_q <= sync_d;
            tb_q <= tb_d;
            evt_q <= evt_d;
            since_q <= since_d;
            tmr_q <= tmr_d;
            rec_q <= rec_d;
            tagged_q <= tagged_d;
            st_q <= st_d;
            cur_e_q <= cur_e_d;
            cur_t_q <= cur_t_d;
            prv_e_q <= prv_e_d;
            prv_t_q <= prv_t_d;
            bas_e_q <= bas_e_d;
            bas_t_q <= bas_t_d;
            res_q <= res_d;
            have_q <= have_d;
            rvld_q <= rvld_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule
`default_nettype wire

// [test/eta_event_timetag_analyzer_props.sv]
`timescale 1ns/100ps
`default_nettype none
module eta_props #(
    parameter int MEM_AW = 23
) (
    // clock, reset, enable, channel
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sig_in,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // first access cycle of a transfer
    logic acc;
    logic bad;
    assign acc = psel && penable && !pready && ce;
    assign bad = (paddr > 8'h30) || (paddr[1:0] != 2'h0);
    // answer timing of the host port
    a_ready_one_wait: assert property (acc |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready && ce |=> !pready)
        else $error("answer held longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("answer outside an access");
    a_ready_cause: assert property ($rose(pready) |-> $past(penable))
        else $error("answer without a request");
    // error reporting on the address
    a_err_qualified: assert property (pslverr |-> pready)
        else $error("error flag without answer");
    a_unmapped_err: assert property (acc && bad |=> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (acc && !bad |=> !pslverr)
        else $error("mapped address refused");
    // read data holds between answers, ce freezes the port
    a_rdata_hold: assert property (!pready |-> $stable(prdata))
        else $error("read data changed outside an answer");
    a_ce_freeze: assert property (!ce |=> $stable(pready))
        else $error("answer moved while clock enable low");
endmodule
bind eta_event_timetag_analyzer eta_props #(.MEM_AW(MEM_AW)) u_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sig_in(sig_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [test/eta_pulse_src.sv]
`timescale 1ns/100ps
`default_nettype none
module eta_pulse_src (
    // clock
    input wire logic clk,
    // digitised channel level
    output logic sig_out
);
    initial sig_out = 1'b0;
    // k pulses of p cycles, half high, idle low after
    task automatic burst(input int k, input int p);
        for (int i = 0; i < k; i++) begin
            sig_out <= 1'b1;
            repeat (p / 2) @(posedge clk);
            sig_out <= 1'b0;
            repeat (p - p / 2) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [test/eta_event_timetag_analyzer_test.sv]
`timescale 1ns/100ps
`default_nettype none
module eta_event_timetag_analyzer_test;
    logic clk, rst_n, ce, sig_in, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    logic [63:0] t0, t1, res;
    int errors, check_count, p, k;
    // clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    eta_pulse_src src (.clk(clk), .sig_out(sig_in));
    eta_event_timetag_analyzer #(.MEM_AW(6)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .sig_in(sig_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (n == 49) errors++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdv(input logic [7:0] a, input logic [63:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // pop a record and wait until the core is idle
    task automatic pop();
        wr(eta_pkg::OFS_CMD, 32'h0000_0001);
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, eta_pkg::OFS_STATUS, 32'h0);
            if (rd[eta_pkg::ST_BUSY] === 1'b0) break;
        end
    endtask
    // disable, drain, rebase, then arm
    task automatic setup(input logic [31:0] ctrl, input logic [31:0] n);
        wr(eta_pkg::OFS_CTRL, 32'h0);
        for (int i = 0; i < 70; i++) begin
            apb(1'b0, eta_pkg::OFS_STATUS, 32'h0);
            if (rd[eta_pkg::ST_EMPTY] !== 1'b0) break;
            pop(); // host keeps draining
        end
        wr(eta_pkg::OFS_CMD, 32'h0000_0002);
        wr(eta_pkg::OFS_ARM_N, n);
        wr(eta_pkg::OFS_CTRL, ctrl);
    endtask
    task automatic pulses(input int n, input int per);
        src.burst(n, per);
        repeat (8) @(posedge clk);
    endtask
    task automatic tag_time(output logic [63:0] t);
        apb(1'b0, eta_pkg::OFS_TAG_TLO, 32'h0);
        t = {32'h0, rd};
    endtask
    // expected result for records 8 events and 8p cycles apart
    function automatic logic [63:0] result(input int f, input longint per,
                                           input longint j);
        case (f)
            0: return (64'd8 << 32) / (8 * per);
            1: return (8 * per << 16) / 8;
            2: return 8 * per;
            default: return 8 * j;
        endcase
    endfunction
    // main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        check_count = 0;
        void'($urandom(86032));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdv(eta_pkg::OFS_CTRL, eta_pkg::CTRL_RST);
        rdv(eta_pkg::OFS_ARM_N, eta_pkg::ARM_N_RST);
        rdv(eta_pkg::OFS_ARM_T, eta_pkg::ARM_T_RST);
        rdv(eta_pkg::OFS_REF, eta_pkg::REF_RST);
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, 8'h05, 32'h0);
        check(err, 1'b1);
        // clock enable low holds the port
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        // every result function over three tags 8 events apart
        for (int f = 0; f < 4; f++) begin
            p = 25 + $urandom % 36;
            setup({26'h0, f[1:0], 4'h1}, 32'd8);
            wr(eta_pkg::OFS_REF, (p << 16) - 1); // reference period
            pulses(17, p);
            rdv(eta_pkg::OFS_EVENTS, 17);
            rdv(eta_pkg::OFS_LEVEL, 3);
            pop();
            rdv(eta_pkg::OFS_TAG_CNT, 1);
            tag_time(t0);
            for (int j = 1; j < 3; j++) begin
                pop();
                rdv(eta_pkg::OFS_TAG_CNT, 8 * j + 1);
                tag_time(t1);
                check(t1 - t0, 8 * p);
                t0 = t1;
                res = result(f, p, j);
                rdv(eta_pkg::OFS_RES_LO, res[31:0]);
                rdv(eta_pkg::OFS_RES_HI, res[63:32]);
            end
        end
        // every-T arming: next tag on first event T cycles on
        p = 25 + $urandom % 36;
        k = (250 + p - 1) / p;
        setup(32'h0000_0025, 32'd1);
        wr(eta_pkg::OFS_ARM_T, 32'd250);
        pulses(k + 3, p);
        pop();
        pop();
        rdv(eta_pkg::OFS_TAG_CNT, k + 1);
        rdv(eta_pkg::OFS_RES_LO, k * p);
        // events every 30 cycles: recovery skips tags, count goes on
        setup(32'h0000_0001, 32'd1);
        pulses(20, 30);
        rdv(eta_pkg::OFS_EVENTS, 20);
        rdv(eta_pkg::OFS_LEVEL, 3);
        // falling slope, slow pulses, every event tagged
        k = 2 + $urandom % 6;
        setup(32'h0000_0003, 32'd1);
        pulses(k, 250);
        rdv(eta_pkg::OFS_EVENTS, k);
        rdv(eta_pkg::OFS_LEVEL, k);
        complete_run();
    end
    // watchdog
    initial begin
        #400000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
